// ---- rtl/lnb_ctrl_pkg.sv ----
// constants, field layouts and types shared by the dual antenna supply controller
package lnb_ctrl_pkg;
    // ==========================================================================
    // timing
    localparam int unsigned SYS_CLK_HZ    = 100_000_000;
    localparam int unsigned TONE_HZ       = 22_000;
    localparam int unsigned CONV_PER_TONE = 10;
    localparam int unsigned CONV_HALF_CYC = SYS_CLK_HZ / (TONE_HZ * CONV_PER_TONE * 2);
    localparam logic [7:0]  CONV_DIV_MAX  = 8'(CONV_HALF_CYC - 1);
    localparam logic [4:0]  TONE_STEP_MAX = 5'(2 * CONV_PER_TONE - 1);
    localparam logic [4:0]  TONE_HALF     = 5'(CONV_PER_TONE);
    // ==========================================================================
    // bus address, upper six bits; the select pin supplies the lowest
    localparam logic [5:0]  SLAVE_ADDR_BASE = 6'h04;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    // ==========================================================================
    // register field positions
    localparam int SR_SEL_BIT = 7;
    localparam int ONE_DCL    = 6;
    localparam int ONE_ISEL   = 5;
    localparam int ONE_FORCE  = 4;
    localparam int ONE_BOOST  = 3;
    localparam int ONE_VOLT   = 2;
    localparam int ONE_ON     = 1;
    localparam int ONE_OLF    = 0;
    localparam int TWO_ISEL   = 6;
    localparam int TWO_FORCE  = 5;
    localparam int TWO_BOOST  = 4;
    localparam int TWO_VOLT   = 3;
    localparam int TWO_ON     = 2;
    localparam int TWO_OTF    = 1;
    localparam int TWO_OLF    = 0;
    localparam logic [7:0] SR_RESET = 8'h00;
    // ==========================================================================
    // output voltage codes
    localparam logic [1:0] VOLT_13V = 2'h0;
    localparam logic [1:0] VOLT_14V = 2'h1;
    localparam logic [1:0] VOLT_18V = 2'h2;
    localparam logic [1:0] VOLT_19V = 2'h3;
    // ==========================================================================
    // types
    typedef struct packed {
        logic isel;
        logic toneForce;
        logic boost;
        logic voltSel;
        logic on;
    } chan_cfg_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       addrSel;
        logic       lockout;
        logic [1:0] key;
        logic [1:0] hv;
        logic [1:0] ovl;
        logic       otf;
    } pin_in_t;

    // bus lines idle high, everything else low
    localparam pin_in_t PIN_IDLE = pin_in_t'(11'h600);

    typedef enum {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WDATA, BUS_WACK, BUS_RDATA, BUS_RACK} bus_state_t;
endpackage : lnb_ctrl_pkg

// ---- rtl/lnb_ctrl.sv ----
// dual antenna supply control: serial register slave, tone gating, voltage codes, converter clock
// Summary of operation
// - A set tone-force bit gives a continuous tone on its channel regardless of the key pin.
// - With tone-force clear the tone follows the channel's key pin, on while high and off while low.
// - Each channel's on bit enables or shuts down that channel's converter; supply lockout also shuts down both.
// - An enabled channel outputs 13V with voltage select low and 18V with it high.
// - A set cable-drop boost bit adds one volt to the selected level.
// - A high on the high-voltage pin forces the 18V setting over the register bit.
// - All operation except the converter clock stops while the supply lockout is active.
// - Both switch drive outputs are held low during supply lockout.
// - The converter clock runs at ten times the tone frequency from the same oscillator.
// - Two registers written over the serial bus hold all settings, read back with status bits.
// - The serial slave works with bus clocks up to 400kHz.
// - The slave answers one of two addresses chosen by the address select pin.
// - Both registers clear to zero at power-on.
module lnb_ctrl (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire lnb_ctrl_pkg::pin_in_t   pins,
    output logic                         sdaOut,
    output logic                         sdaOe,
    output logic [1:0]                   chanOn,
    output logic [1:0][1:0]              voltCode,
    output logic [1:0]                   toneOut,
    output logic [1:0]                   switchDrive,
    output logic [1:0]                   currentSel,
    output logic                         dclMode,
    output logic                         convClk
);
    import lnb_ctrl_pkg::*;

    // ==========================================================================
    // pin synchronisers
    pin_in_t    pinS1_q;
    pin_in_t    pinS2_q;
    pin_in_t    pinS3_q;
    logic       lock;

    // two flops on every pin, third stage for bus edges
    // oversampled bus
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinS1_q <= PIN_IDLE;
            pinS2_q <= PIN_IDLE;
            pinS3_q <= PIN_IDLE;
        end else begin
            pinS1_q <= pins;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
        end
    end

    assign lock = pinS2_q.lockout;

    // ==========================================================================
    // converter and tone timebase
    logic [7:0] divCnt_q;
    logic       convTick;
    logic [4:0] toneCnt_q;
    logic       periodStart;
    logic       convClk_q;

    assign convTick    = (divCnt_q == CONV_DIV_MAX);
    assign periodStart = convTick && (toneCnt_q == TONE_STEP_MAX);

    // half-period divider of the converter clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= convTick ? 8'h00 : divCnt_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            convClk_q <= 1'b0;
            toneCnt_q <= 5'h00;
        end else if (convTick) begin
            convClk_q <= ~convClk_q;
            toneCnt_q <= (toneCnt_q == TONE_STEP_MAX) ? 5'h00 : toneCnt_q + 5'h01;
        end
    end

    // ==========================================================================
    // register storage
    chan_cfg_t [1:0] cfg_q;
    logic            dcl_q;

    // decode one written byte into a channel setting
    function automatic chan_cfg_t decodeCfg(input logic [7:0] b);
        chan_cfg_t c;
        if (!b[SR_SEL_BIT]) begin
            c = '{isel: b[ONE_ISEL], toneForce: b[ONE_FORCE], boost: b[ONE_BOOST],
                  voltSel: b[ONE_VOLT], on: b[ONE_ON]};
        end else begin
            c = '{isel: b[TWO_ISEL], toneForce: b[TWO_FORCE], boost: b[TWO_BOOST],
                  voltSel: b[TWO_VOLT], on: b[TWO_ON]};
        end
        return c;
    endfunction : decodeCfg

    // read-back image of one register with live status
    function automatic logic [7:0] readImage(input logic sel, input chan_cfg_t c, input logic d,
                                             input logic [1:0] ovl, input logic otf);
        logic [7:0] b;
        b = 8'h00;
        if (!sel) begin
            b[ONE_DCL]   = d;
            b[ONE_ISEL]  = c.isel;
            b[ONE_FORCE] = c.toneForce;
            b[ONE_BOOST] = c.boost;
            b[ONE_VOLT]  = c.voltSel;
            b[ONE_ON]    = c.on;
            b[ONE_OLF]   = ovl[0];
        end else begin
            b[SR_SEL_BIT] = 1'b1;
            b[TWO_ISEL]   = c.isel;
            b[TWO_FORCE]  = c.toneForce;
            b[TWO_BOOST]  = c.boost;
            b[TWO_VOLT]   = c.voltSel;
            b[TWO_ON]     = c.on;
            b[TWO_OTF]    = otf;
            b[TWO_OLF]    = ovl[1];
        end
        return b;
    endfunction : readImage

    // ==========================================================================
    // serial bus slave
    bus_state_t state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] txByte_q;
    logic       rdSel_q;
    logic       rw_q;
    logic       sdaOe_q;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic       addrHit;
    logic       byteDone;
    logic [7:0] rdImage;

    assign sclRise   = pinS2_q.scl && !pinS3_q.scl;
    assign sclFall   = !pinS2_q.scl && pinS3_q.scl;
    assign startCond = pinS2_q.scl && pinS3_q.scl && pinS3_q.sda && !pinS2_q.sda;
    assign stopCond  = pinS2_q.scl && pinS3_q.scl && !pinS3_q.sda && pinS2_q.sda;
    assign byteDone  = (bitCnt_q == BITS_PER_BYTE);
    assign addrHit   = (shift_q[7:1] == {SLAVE_ADDR_BASE, pinS2_q.addrSel});
    // image of the register due next on a read
    assign rdImage   = readImage(rdSel_q, cfg_q[rdSel_q], dcl_q, pinS2_q.ovl, pinS2_q.otf);

    // bit shifter, sampled on rising bus clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shift_q  <= 8'h00;
            bitCnt_q <= 4'h0;
        end else if (startCond) begin
            bitCnt_q <= 4'h0;
        end else if (sclRise && (state_q == BUS_ADDR || state_q == BUS_WDATA || state_q == BUS_RDATA)) begin
            shift_q  <= {shift_q[6:0], pinS2_q.sda};
            bitCnt_q <= bitCnt_q + 4'h1;
        end else if (sclFall && (state_q == BUS_ADDR_ACK || state_q == BUS_WACK || state_q == BUS_RACK)) begin
            bitCnt_q <= 4'h0;
        end
    end

    // bus state machine and data line drive
    // no acknowledge under lockout
    always_ff @(posedge sys_clk) begin
        sdaOut <= 1'b0; // open drain: only the enable moves
        if (reset || lock) begin
            state_q  <= BUS_IDLE;
            sdaOe_q  <= 1'b0;
            rw_q     <= 1'b0;
            rdSel_q  <= 1'b0;
            txByte_q <= 8'h00;
        end else if (startCond) begin
            state_q <= BUS_ADDR;
            sdaOe_q <= 1'b0;
        end else if (stopCond) begin
            state_q <= BUS_IDLE;
            sdaOe_q <= 1'b0;
        end else begin
            case (state_q)
                BUS_ADDR: begin
                    if (sclFall && byteDone) begin
                        state_q <= addrHit ? BUS_ADDR_ACK : BUS_IDLE;
                        sdaOe_q <= addrHit;
                        rw_q    <= shift_q[0];
                        rdSel_q <= 1'b0;
                    end
                end
                BUS_ADDR_ACK, BUS_RACK: begin
                    if (sclRise && state_q == BUS_RACK && pinS2_q.sda) begin
                        state_q <= BUS_IDLE;
                    end else if (sclFall) begin
                        if (rw_q) begin
                            txByte_q <= rdImage;
                            sdaOe_q  <= !rdImage[7]; // msb goes out first
                            rdSel_q  <= ~rdSel_q;
                            state_q  <= BUS_RDATA;
                        end else begin
                            sdaOe_q <= 1'b0;
                            state_q <= BUS_WDATA;
                        end
                    end
                end
                BUS_WDATA: begin
                    if (sclFall && byteDone) begin
                        sdaOe_q <= 1'b1;
                        state_q <= BUS_WACK;
                    end
                end
                BUS_WACK: begin
                    if (sclFall) begin
                        sdaOe_q <= 1'b0;
                        state_q <= BUS_WDATA;
                    end
                end
                BUS_RDATA: begin
                    if (sclFall) begin
                        sdaOe_q <= byteDone ? 1'b0 : !txByte_q[3'(7 - 32'(bitCnt_q))];
                        state_q <= byteDone ? BUS_RACK : BUS_RDATA;
                    end
                end
                default: begin
                    state_q <= BUS_IDLE;
                    sdaOe_q <= 1'b0;
                end
            endcase
        end
    end

    // register write at the end of a data byte
    // cleared at reset and in lockout
    always_ff @(posedge sys_clk) begin
        if (reset || lock) begin
            cfg_q <= {2{chan_cfg_t'(SR_RESET[4:0])}};
            dcl_q <= 1'b0;
        end else if (state_q == BUS_WDATA && sclFall && byteDone) begin
            cfg_q[shift_q[SR_SEL_BIT]] <= decodeCfg(shift_q);
            if (!shift_q[SR_SEL_BIT]) begin
                dcl_q <= shift_q[ONE_DCL];
            end
        end
    end

    // ==========================================================================
    // channel outputs
    logic [1:0] toneGate_q;
    logic [1:0] chanOn_q;
    logic [1:0][1:0] voltCode_q;
    logic [1:0] toneOut_q;
    logic [1:0] switchDrive_q;

    // gate changes only at a tone period start
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            toneGate_q <= 2'h0;
        end else if (periodStart) begin
            for (int ch = 0; ch < 2; ch++) begin
                toneGate_q[ch] <= cfg_q[ch].toneForce || pinS2_q.key[ch];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chanOn_q      <= 2'h0;
            voltCode_q    <= '0;
            toneOut_q     <= 2'h0;
            switchDrive_q <= 2'h0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                chanOn_q[ch]      <= cfg_q[ch].on && !lock;
                voltCode_q[ch]    <= (cfg_q[ch].on && !lock) ?
                                     {cfg_q[ch].voltSel || pinS2_q.hv[ch], cfg_q[ch].boost} : VOLT_13V;
                toneOut_q[ch]     <= toneGate_q[ch] && cfg_q[ch].on && !lock && (toneCnt_q < TONE_HALF);
                switchDrive_q[ch] <= convClk_q && cfg_q[ch].on && !lock;
            end
        end
    end

    assign sdaOe       = sdaOe_q;
    assign chanOn      = chanOn_q;
    assign voltCode    = voltCode_q;
    assign toneOut     = toneOut_q;
    assign switchDrive = switchDrive_q;
    assign currentSel  = {cfg_q[1].isel, cfg_q[0].isel};
    assign dclMode     = dcl_q;
    assign convClk     = convClk_q;

    // ==========================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_FORCE_TONE: assert property (periodStart && cfg_q[0].toneForce |=> toneGate_q[0])
        else $error("forced tone not gated on");
    AST_KEY_OFF: assert property (periodStart && !cfg_q[1].toneForce && !pinS2_q.key[1] |=> !toneGate_q[1])
        else $error("tone gated on with key low and force clear");
    AST_GATE_HOLD: assert property (!periodStart |=> $stable(toneGate_q))
        else $error("tone gate moved mid period");
    AST_CHAN_OFF: assert property (!cfg_q[0].on |=> !chanOn_q[0] && switchDrive_q[0] == 1'b0)
        else $error("disabled channel still active");
    AST_VOLT_13: assert property (cfg_q[0].on && !lock && !cfg_q[0].voltSel && !pinS2_q.hv[0] && !cfg_q[0].boost
                                  |=> voltCode_q[0] == VOLT_13V)
        else $error("13V code wrong");
    AST_BOOST: assert property (cfg_q[1].on && !lock && cfg_q[1].boost |=> voltCode_q[1][0])
        else $error("boost not applied");
    AST_HV_PIN: assert property (cfg_q[0].on && !lock && pinS2_q.hv[0] && !cfg_q[0].boost
                                 |=> voltCode_q[0] == VOLT_18V)
        else $error("high-voltage pin ignored");
    AST_LOCK_OFF: assert property (lock |=> chanOn_q == 2'h0 && toneOut_q == 2'h0 && cfg_q == '0)
        else $error("activity during lockout");
    AST_LOCK_DRIVE: assert property (lock |=> switchDrive_q == 2'h0)
        else $error("switch drive during lockout");
    AST_CONV_TOGGLE: assert property (convTick |=> convClk_q != $past(convClk_q) ##1 $stable(convClk_q))
        else $error("converter clock not toggling on tick");
    AST_ADDR_ACK: assert property (state_q == BUS_ADDR && sclFall && byteDone && !startCond && !stopCond && !lock
                                   |=> sdaOe_q == $past(addrHit))
        else $error("address acknowledge wrong");

    COV_WRITE: cover property (state_q == BUS_WACK && sclFall);
    COV_READ: cover property (state_q == BUS_RACK && sclFall);
    COV_BURST: cover property (periodStart && !cfg_q[1].toneForce && pinS2_q.key[1]);
    COV_LOCK: cover property ($rose(lock));
endmodule : lnb_ctrl

// ---- sim/lnb_host_model.sv ----
// two-wire bus master standing in for the host controller
module lnb_host_model
    import lnb_ctrl_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================================
    // bit timing
    localparam int QTR = 125; // 250 cycles a bit, 400kHz

    // bus free, both lines released
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : hold

    // data moves only while scl low, a little after its fall
    task automatic bit_x(input logic b, output logic r);
        hold(2);
        sda = b;
        hold(QTR - 2);
        scl = 1'b1;
        hold(QTR);
        r   = sdaWire; // taken just before scl falls
        scl = 1'b0;
    endtask : bit_x

    // one byte msb first, then the acknowledge slot
    task automatic byte_x(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(ackOut, a);
        acked = !a;
    endtask : byte_x

    task automatic start_c();
        sda = 1'b1;
        scl = 1'b1;
        hold(QTR);
        sda = 1'b0;
        hold(QTR);
        scl = 1'b0;
    endtask : start_c

    task automatic stop_c();
        hold(2);
        sda = 1'b0;
        hold(QTR);
        scl = 1'b1;
        hold(QTR);
        sda = 1'b1;
        hold(QTR);
    endtask : stop_c

    // address, then both registers; a refused address ends the transfer
    task automatic host_write(input logic lsb, input logic [7:0] d1, input logic [7:0] d2, output logic ack);
        logic [7:0] junk;
        logic       a2;
        start_c();
        byte_x({SLAVE_ADDR_BASE, lsb, 1'b0}, 1'b1, junk, ack);
        if (ack) begin
            byte_x(d1, 1'b1, junk, a2);
            ack = ack & a2;
            byte_x(d2, 1'b1, junk, a2);
            ack = ack & a2;
        end
        stop_c();
    endtask : host_write

    // two bytes read back, master nack on the last
    task automatic host_read(input logic lsb, output logic [7:0] d1, output logic [7:0] d2, output logic ack);
        logic a2;
        start_c();
        byte_x({SLAVE_ADDR_BASE, lsb, 1'b1}, 1'b1, d1, ack);
        byte_x(8'hFF, 1'b0, d1, a2);
        byte_x(8'hFF, 1'b1, d2, a2);
        stop_c();
    endtask : host_read
endmodule : lnb_host_model

// ---- sim/tb_lnb_ctrl.sv ----
// self-checking bench for the dual antenna supply controller
module tb_lnb_ctrl
    import lnb_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================================
    // signals
    typedef struct packed {
        logic [7:0] r1;
        logic [7:0] r2;
        logic [1:0] hv;
        logic [8:0] exp; // on, volt codes, isel, dcl
    } row_t;
    localparam int LIMIT = 100000;
    logic             sys_clk;
    logic             reset;
    logic             scl;
    logic             sdaHost;
    logic             sdaWire;
    logic             addrSel;
    logic             lockout;
    logic [1:0]       key;
    logic [1:0]       hv;
    logic [1:0]       ovl;
    logic             otf;
    pin_in_t          pins;
    logic             sdaOut;
    logic             sdaOe;
    logic [1:0]       chanOn;
    logic [1:0][1:0]  voltCode;
    logic [1:0]       toneOut;
    logic [1:0]       switchDrive;
    logic [1:0]       currentSel;
    logic             dclMode;
    logic             convClk;
    logic             ack;
    logic [7:0]       d1;
    logic [7:0]       d2;
    logic [7:0]       e0;
    logic [7:0]       e1;
    logic [15:0]      w;
    logic [15:0]      sdHi;
    int               errors = 0;
    int               samplesChecked = 0;
    int               cycles = 0;
    row_t rows [5] = '{'{8'h02, 8'h80, 2'h0, 9'h080}, '{8'h0E, 8'h84, 2'h0, 9'h198},
                       '{8'h4A, 8'hCC, 2'h0, 9'h1CD}, '{8'h22, 8'h94, 2'h3, 9'h1F2},
                       '{8'h00, 8'h80, 2'h3, 9'h000}};

    // open-drain data line with pull-up
    assign sdaWire = sdaHost & !sdaOe;
    assign pins = '{scl: scl, sda: sdaWire, addrSel: addrSel, lockout: lockout,
                    key: key, hv: hv, ovl: ovl, otf: otf};

    lnb_ctrl i_lnb_ctrl (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .pins        (pins),
        .sdaOut      (sdaOut),
        .sdaOe       (sdaOe),
        .chanOn      (chanOn),
        .voltCode    (voltCode),
        .toneOut     (toneOut),
        .switchDrive (switchDrive),
        .currentSel  (currentSel),
        .dclMode     (dclMode),
        .convClk     (convClk)
    );

    lnb_host_model i_lnb_host_model (
        .sys_clk (sys_clk),
        .sdaWire (sdaWire),
        .scl     (scl),
        .sda     (sdaHost)
    );
    // ==========================================================================
    // helpers
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic closeOut();
        if (errors == 0 && samplesChecked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : closeOut

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            closeOut();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    // tone toggles per channel and cycles with any gate drive high
    task automatic window(input int n);
        logic [1:0] prev;
        e0 = 8'h00;
        e1 = 8'h00;
        sdHi = 16'h0000;
        prev = toneOut;
        repeat (n) begin
            @(negedge sys_clk);
            if (toneOut[0] !== prev[0]) e0++;
            if (toneOut[1] !== prev[1]) e1++;
            if (switchDrive !== 2'h0) sdHi++;
            prev = toneOut;
        end
    endtask : window

    function automatic logic pick(input logic s);
        return s ? toneOut[1] : convClk;
    endfunction : pick

    // cycles between two changes of convClk or of tone two
    task automatic span(input logic s);
        logic v0;
        v0 = pick(s);
        w = 16'h0000;
        for (int i = 0; i < 10000 && pick(s) === v0; i++) @(negedge sys_clk);
        v0 = pick(s);
        for (int i = 0; i < 10000 && pick(s) === v0; i++) begin
            @(negedge sys_clk);
            w++;
        end
    endtask : span
    // ==========================================================================
    // main sequence
    initial begin
        reset = 1'b1;
        addrSel = 1'b1;
        lockout = 1'b0;
        key = 2'h0;
        hv = 2'h0;
        ovl = 2'h0;
        otf = 1'b0;
        idle(16);
        reset = 1'b0;
        idle(1);
        check(32'({chanOn, voltCode, currentSel, dclMode, toneOut, switchDrive}), 32'h0);
        idle(4);
        i_lnb_host_model.host_write(1'b0, 8'h02, 8'h80, ack);
        check(32'({ack, chanOn}), 32'h0);
        foreach (rows[i]) begin
            hv = rows[i].hv;
            i_lnb_host_model.host_write(1'b1, rows[i].r1, rows[i].r2, ack);
            idle(8);
            check(32'({ack, chanOn, voltCode, currentSel, dclMode}), 32'({1'b1, rows[i].exp}));
        end
        hv = 2'h0;
        i_lnb_host_model.host_write(1'b1, 8'h4A, 8'hCC, ack);
        ovl = 2'h1;
        otf = 1'b1;
        i_lnb_host_model.host_read(1'b1, d1, d2, ack);
        check(32'({ack, d1, d2}), 32'h14BCE);
        ovl = 2'h0;
        otf = 1'b0;
        // second reset in mid-run clears written settings
        reset = 1'b1;
        idle(16);
        reset = 1'b0;
        idle(2);
        check(32'({chanOn, voltCode, currentSel, dclMode, toneOut, switchDrive}), 32'h0);
        span(1'b0);
        check(32'(w), 32'(CONV_HALF_CYC));
        // force two clear while key two bursts
        key = 2'h2;
        i_lnb_host_model.host_write(1'b1, 8'h12, 8'h84, ack);
        idle(4550);
        window(4540);
        check(32'({e0, e1, sdHi}), 32'({16'h0202, 16'(CONV_PER_TONE * CONV_HALF_CYC)}));
        span(1'b1);
        check(32'(w), 32'(CONV_PER_TONE * CONV_HALF_CYC));
        key = 2'h0;
        idle(4550);
        window(4540);
        check(32'({e0, e1}), 32'h0200);
        lockout = 1'b1;
        idle(8);
        window(908);
        check(32'({chanOn, e0, e1, sdHi}), 32'h0);
        lockout = 1'b0;
        idle(8);
        i_lnb_host_model.host_read(1'b1, d1, d2, ack);
        check(32'({sdaOut, d1, d2}), 32'h0080);
        closeOut();
    end
endmodule : tb_lnb_ctrl
